// ===== logic/wsl_pkg.sv
// Shared constants, encodings and decode helpers for the write-once security lock
package wsl_pkg;
  localparam int KEY_W = 32;
  localparam int MATCH_MIN = 28;
  // Key pattern default is an arbitrary value, not tied to any real part
  localparam logic [31:0] KEY_PATTERN_DEF = 32'hA5C31E69;
  localparam int PROT_W = 2;
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_RESET = 2'h0;
  localparam logic [31:0] KEY_RESET = 32'h00000000;
  localparam logic [1:0] OP_ERASE = 2'h0;
  localparam logic [1:0] OP_PROGRAM = 2'h1;
  localparam logic [1:0] OP_VERIFY = 2'h2;
  localparam logic [1:0] SEC_OPEN = 2'h0;
  localparam logic [1:0] SEC_NO_READ = 2'h1;
  localparam logic [1:0] SEC_NO_WRITE = 2'h2;
  localparam logic [1:0] SEC_SEALED = 2'h3;

  typedef enum logic [2:0] {
    WSL_OPEN = 3'h1,
    WSL_ARMED = 3'h2,
    WSL_LOCKED = 3'h4
  } wsl_state_t;

  // Whether a block with setting sec lets operation op run
  function automatic logic wsl_blk_permit(input logic [1:0] sec, input logic [1:0] op);
    logic ok;
    ok = 1'b0;
    case (sec)
      SEC_OPEN: ok = (op != 2'h3);
      SEC_NO_READ: ok = (op == OP_ERASE) || (op == OP_PROGRAM);
      SEC_NO_WRITE: ok = (op == OP_VERIFY);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : wsl_blk_permit
endpackage : wsl_pkg

// ===== logic/wsl_vote.sv
// Super-majority comparator wrapped around the latch cells
`timescale 1ns/1ps
module wsl_vote
  import wsl_pkg::*;
#(
  parameter int WIDTH = KEY_W,
  parameter int THRESH = MATCH_MIN,
  parameter logic [31:0] PATTERN = KEY_PATTERN_DEF
) (
  input wire logic [WIDTH-1:0] cells_i,
  output logic match_o
);
  logic [WIDTH-1:0] agree;
  logic [7:0] votes [0:WIDTH];

  assign agree = ~(cells_i ^ PATTERN[WIDTH-1:0]);
  assign votes[0] = 8'h00;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_sum
      assign votes[g+1] = votes[g] + {7'h00, agree[g]};
    end
  endgenerate

  // A few failed bits cannot drop the output
  assign match_o = (votes[WIDTH] >= 8'(THRESH));
endmodule : wsl_vote

// ===== logic/wsl_lock.sv
// Write-once security lock: key latch, reset-sampled lockout and flash gating
`timescale 1ns/1ps
// Functional notes
// - Latch holds one 32-bit key word
// - Output one when 28 of 32 bits match
// - Locked: all debug and test ports off
// - Locked: latch can never be altered
// - Lock needs load, commit, then reset
// - Latch output sampled only during reset
// - Key write only with no flash protection
// - Access stays open until next reset
// - Latch readable through serial-wire port
// - Protection rises only; full erase clears it
// - Block ops obey block security setting
module wsl_lock
  import wsl_pkg::*;
#(
  parameter logic [31:0] KEY_PATTERN = KEY_PATTERN_DEF
) (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic NV_PRELOAD_I,
  input wire logic [KEY_W-1:0] NV_PRELOAD_DATA_I,
  input wire logic KEY_LOAD_I,
  input wire logic [KEY_W-1:0] KEY_DATA_I,
  input wire logic KEY_COMMIT_I,
  input wire logic DEBUG_REQ_I,
  input wire logic TEST_REQ_I,
  input wire logic PROT_SET_I,
  input wire logic [PROT_W-1:0] PROT_VALUE_I,
  input wire logic DEVICE_ERASE_I,
  input wire logic BLK_REQ_I,
  input wire logic [1:0] BLK_OP_I,
  input wire logic [1:0] BLK_SEC_I,
  input wire logic LATCH_READ_I,
  output logic LOCKED_O,
  output logic DEBUG_EN_O,
  output logic TEST_EN_O,
  output logic KEY_MATCH_O,
  output logic ARMED_O,
  output logic KEY_ACCEPT_O,
  output logic KEY_REJECT_O,
  output logic COMMIT_DONE_O,
  output logic [PROT_W-1:0] PROT_LEVEL_O,
  output logic BLK_GO_O,
  output logic BLK_DENY_O,
  output logic [KEY_W-1:0] LATCH_DATA_O,
  output logic LATCH_VALID_O
);
  logic [KEY_W-1:0] nv_cells;
  logic [KEY_W-1:0] vol_key;
  logic key_loaded;
  logic lock;
  logic [PROT_W-1:0] prot;
  wsl_state_t state;
  wsl_state_t next_state;
  logic match_live;
  logic host_ok;
  logic key_ok;
  logic commit_ok;
  logic prot_ok;
  logic erase_ok;
  logic blk_ok;

  wsl_vote #(
    .WIDTH(KEY_W),
    .THRESH(MATCH_MIN),
    .PATTERN(KEY_PATTERN)
  ) u_vote (
    .cells_i(nv_cells),
    .match_o(match_live)
  );

  // Host requests other than latch reads count only while the reset-sampled lock is clear
  assign host_ok = !lock;
  assign key_ok = KEY_LOAD_I && host_ok && !match_live && (prot == PROT_NONE);
  assign commit_ok = KEY_COMMIT_I && host_ok && key_loaded && !match_live;
  assign prot_ok = PROT_SET_I && host_ok && (PROT_VALUE_I > prot);
  assign erase_ok = DEVICE_ERASE_I && host_ok;
  assign blk_ok = BLK_REQ_I && host_ok && wsl_blk_permit(BLK_SEC_I, BLK_OP_I);

  always_comb begin
    next_state = state;
    case (state)
      WSL_OPEN: if (commit_ok) next_state = WSL_ARMED;
      WSL_ARMED: next_state = WSL_ARMED;
      WSL_LOCKED: next_state = WSL_LOCKED;
      default: next_state = WSL_OPEN;
    endcase
  end

  // Cells keep their content through reset; only preload or commit change them
  always_ff @(posedge CLOCK_I) begin
    if (NV_PRELOAD_I && !match_live) begin
      nv_cells <= NV_PRELOAD_DATA_I;
    end else if (!SRST_I && commit_ok) begin
      nv_cells <= vol_key;
    end
  end

  // Lock decision is taken from the wrapper only while reset is held
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      lock <= match_live;
      state <= match_live ? WSL_LOCKED : WSL_OPEN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      vol_key <= KEY_RESET;
      key_loaded <= 1'b0;
    end else begin
      if (key_ok) begin
        vol_key <= KEY_DATA_I;
        key_loaded <= 1'b1;
      end
    end
  end

  // Protection is nonvolatile: reset keeps it, only erase or factory preload clears it
  always_ff @(posedge CLOCK_I) begin
    if (NV_PRELOAD_I || (!SRST_I && erase_ok)) begin
      prot <= PROT_NONE;
    end else if (!SRST_I && prot_ok) begin
      prot <= PROT_VALUE_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      LOCKED_O <= match_live;
      DEBUG_EN_O <= 1'b0;
      TEST_EN_O <= 1'b0;
      KEY_MATCH_O <= 1'b0;
      ARMED_O <= 1'b0;
      KEY_ACCEPT_O <= 1'b0;
      KEY_REJECT_O <= 1'b0;
      COMMIT_DONE_O <= 1'b0;
      PROT_LEVEL_O <= PROT_RESET;
      BLK_GO_O <= 1'b0;
      BLK_DENY_O <= 1'b0;
      LATCH_DATA_O <= KEY_RESET;
      LATCH_VALID_O <= 1'b0;
    end else begin
      LOCKED_O <= lock;
      DEBUG_EN_O <= DEBUG_REQ_I && host_ok;
      TEST_EN_O <= TEST_REQ_I && host_ok;
      KEY_MATCH_O <= match_live;
      ARMED_O <= (state == WSL_ARMED);
      KEY_ACCEPT_O <= key_ok;
      KEY_REJECT_O <= KEY_LOAD_I && !key_ok;
      COMMIT_DONE_O <= commit_ok;
      PROT_LEVEL_O <= erase_ok ? PROT_NONE : (prot_ok ? PROT_VALUE_I : prot);
      BLK_GO_O <= blk_ok;
      BLK_DENY_O <= BLK_REQ_I && !blk_ok;
      LATCH_VALID_O <= LATCH_READ_I;
      if (LATCH_READ_I) begin
        LATCH_DATA_O <= nv_cells;
      end
    end
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (SRST_I);

  sequence s_blk_refused;
    BLK_REQ_I && !wsl_blk_permit(BLK_SEC_I, BLK_OP_I);
  endsequence
  sequence s_refusal_shown;
    BLK_DENY_O && !BLK_GO_O;
  endsequence
  sequence s_key_loaded;
    KEY_LOAD_I && host_ok && !match_live && (prot == PROT_NONE);
  endsequence

  a_blk_gate: assert property (s_blk_refused |=> s_refusal_shown)
    else $error("refused block operation was started");
  a_ports_off: assert property (lock |=> !DEBUG_EN_O && !TEST_EN_O)
    else $error("debug or test enabled while locked");
  a_lock_held: assert property (!$stable(nv_cells) |-> $stable(lock))
    else $error("lock changed outside reset");
  a_lock_sample: assert property (@(posedge CLOCK_I) disable iff (1'b0)
    SRST_I && !NV_PRELOAD_I |=> lock == $past(match_live))
    else $error("lock not sampled from wrapper in reset");
  a_latch_frozen: assert property (match_live |=> $stable(nv_cells))
    else $error("frozen latch was altered");
  a_key_refused: assert property (KEY_LOAD_I && (prot != PROT_NONE) |=> KEY_REJECT_O)
    else $error("key accepted with protection set");
  a_armed_open: assert property (state == WSL_ARMED && DEBUG_REQ_I |=> DEBUG_EN_O)
    else $error("access lost before reset");
  a_prot_lower: assert property (prot < $past(prot) |-> $past(erase_ok) || $past(NV_PRELOAD_I))
    else $error("protection lowered without erase");
  a_commit_path: assert property (s_key_loaded ##1 KEY_COMMIT_I && !lock ##1 1'b1
    |-> COMMIT_DONE_O)
    else $error("commit after full key load not done");
  a_vote_count: assert property (match_live == ($countones(~(nv_cells ^ KEY_PATTERN)) >= MATCH_MIN))
    else $error("wrapper output disagrees with bit count");
  a_latch_read: assert property (LATCH_READ_I |=> LATCH_VALID_O && LATCH_DATA_O == $past(nv_cells))
    else $error("latch read returned wrong word");
  a_commit_arms: assert property (COMMIT_DONE_O |=> ARMED_O)
    else $error("commit did not arm the lock");
  a_key_taken: assert property (s_key_loaded |=> KEY_ACCEPT_O)
    else $error("permitted key load not accepted");
  a_blk_go: assert property (BLK_REQ_I && !lock && wsl_blk_permit(BLK_SEC_I, BLK_OP_I)
    |=> BLK_GO_O)
    else $error("permitted block operation not started");
  a_erase_clear: assert property (DEVICE_ERASE_I && !lock |=> PROT_LEVEL_O == PROT_NONE)
    else $error("device erase left protection set");
  a_prot_raise: assert property (PROT_SET_I && !lock && !DEVICE_ERASE_I && (PROT_VALUE_I > prot)
    |=> prot == $past(PROT_VALUE_I))
    else $error("protection raise not taken");
  a_lock_stays: assert property (lock |=> lock)
    else $error("lock cleared outside reset");
endmodule : wsl_lock

// ===== tb/wsl_host.sv
// Programming host model: key load, commit and protection requests
`timescale 1ns/1ps
module wsl_host (
  input wire logic clk_i,
  output logic key_load_o,
  output logic [31:0] key_data_o,
  output logic key_commit_o,
  output logic prot_set_o,
  output logic [1:0] prot_value_o
);
  initial begin
    key_load_o = 1'b0;
    key_data_o = 32'h0;
    key_commit_o = 1'b0;
    prot_set_o = 1'b0;
    prot_value_o = 2'h0;
  end
  // Whole key word per load; released data is inverted
  task automatic load(input logic [31:0] k);
    @(posedge clk_i);
    key_load_o <= 1'b1;
    key_data_o <= k;
    @(posedge clk_i);
    key_load_o <= 1'b0;
    key_data_o <= ~k;
    #1;
  endtask : load
  task automatic protect(input logic [1:0] v);
    @(posedge clk_i);
    prot_set_o <= 1'b1;
    prot_value_o <= v;
    @(posedge clk_i);
    prot_set_o <= 1'b0;
    prot_value_o <= ~v;
    #1;
  endtask : protect
  task automatic lock_seq(input logic [31:0] k);
    @(posedge clk_i);
    key_load_o <= 1'b1;
    key_data_o <= k;
    @(posedge clk_i);
    key_load_o <= 1'b0;
    key_data_o <= ~k;
    key_commit_o <= 1'b1;
    @(posedge clk_i);
    key_commit_o <= 1'b0;
    #1;
    protect(2'h1);
  endtask : lock_seq
endmodule : wsl_host

// ===== tb/wsl_lock_tb_top.sv
// Self-checking bench for the write-once security lock
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module wsl_lock_tb_top;
  import wsl_pkg::*;
  logic clk = 0, rst = 1, pre = 1, dbg = 0, tst = 0, ers = 0, breq = 0, lrd = 0;
  logic [31:0] pre_d, st = 32'h6490a195, k, kd, ld;
  logic [1:0] bop = 0, bsec = 0, pv, pl;
  logic kl, kc, ps, lk, de, te, km, ar, ka, kr, cd, bg, bd, lv;
  int n_fail = 0, total_checks = 0, ok;
  always #2 clk = ~clk;
  wsl_host u_host (.clk_i(clk), .key_load_o(kl), .key_data_o(kd), .key_commit_o(kc),
    .prot_set_o(ps), .prot_value_o(pv));
  wsl_lock u_dut (.CLOCK_I(clk), .SRST_I(rst), .NV_PRELOAD_I(pre), .NV_PRELOAD_DATA_I(pre_d),
    .KEY_LOAD_I(kl), .KEY_DATA_I(kd), .KEY_COMMIT_I(kc), .DEBUG_REQ_I(dbg), .TEST_REQ_I(tst),
    .PROT_SET_I(ps), .PROT_VALUE_I(pv), .DEVICE_ERASE_I(ers), .BLK_REQ_I(breq),
    .BLK_OP_I(bop), .BLK_SEC_I(bsec), .LATCH_READ_I(lrd), .LOCKED_O(lk), .DEBUG_EN_O(de),
    .TEST_EN_O(te), .KEY_MATCH_O(km), .ARMED_O(ar), .KEY_ACCEPT_O(ka), .KEY_REJECT_O(kr),
    .COMMIT_DONE_O(cd), .PROT_LEVEL_O(pl), .BLK_GO_O(bg), .BLK_DENY_O(bd),
    .LATCH_DATA_O(ld), .LATCH_VALID_O(lv));
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction : rnd
  // Pattern with exactly n random bits turned round
  function automatic logic [31:0] flip(input int n);
    logic [31:0] m;
    m = 32'h0;
    while ($countones(m) < n) m = m | (32'h1 << (rnd() % 32));
    return KEY_PATTERN_DEF ^ m;
  endfunction : flip
  function automatic logic votes(input logic [31:0] v);
    return $countones(~(v ^ KEY_PATTERN_DEF)) >= MATCH_MIN;
  endfunction : votes
  task automatic do_rst(input int n);
    @(posedge clk);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    pre <= 1'b0;
    #1;
  endtask : do_rst
  task automatic strobe(input int w);
    @(posedge clk);
    if (w == 0) ers <= 1'b1;
    else lrd <= 1'b1;
    @(posedge clk);
    ers <= 1'b0;
    lrd <= 1'b0;
    breq <= 1'b0;
    #1;
  endtask : strobe
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    #4000;
    n_fail++;
    end_sim();
  end
  initial begin
    pre_d = flip(12);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    pre <= 1'b0;
    dbg <= 1'b1;
    tst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(lk, votes(pre_d))
    `CHK({de, te}, 2'h3)
    $display("done: open access");
    u_host.protect(2'h2);
    u_host.protect(2'h1);
    `CHK(pl, 2'h2)
    u_host.load(KEY_PATTERN_DEF);
    `CHK(kr, 1'b1)
    strobe(0);
    `CHK(pl, 2'h0)
    $display("done: protection");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      breq <= 1'b1;
      bop <= i[1:0];
      bsec <= i[3:2];
      ok = (i < 3) || (i == 4) || (i == 5) || (i == 10);
      strobe(1);
      `CHK({bg, bd}, {ok[0], !ok[0]})
    end
    $display("done: block ops");
    pre_d = flip(5);
    pre <= 1'b1;
    do_rst(2);
    strobe(1);
    `CHK({lk, lv, ld}, {1'b0, 1'b1, pre_d})
    k = flip(4);
    u_host.lock_seq(k);
    `CHK({ar, km, pl, de, lk}, {1'b1, votes(k), 2'h1, 1'b1, 1'b0})
    do_rst(1);
    repeat (2) @(posedge clk);
    #1;
    `CHK({lk, de, te}, 3'h4)
    u_host.load(~k);
    `CHK(kr, 1'b1)
    strobe(1);
    `CHK(ld, k)
    do_rst(1);
    `CHK(lk, votes(k))
    $display("done: lockout");
    end_sim();
  end
endmodule : wsl_lock_tb_top
